/* include/eesrp_pkg.sv */
/*
 eesrp_pkg: constants and types shared by the serial eeprom read path.
 Assumes it is compiled before any design file that imports it.
*/
package eesrp_pkg;

	// address widths of the array and the identification page
	localparam int ADDR_W    = 18;
	localparam int ID_AW     = 8;

	// select byte layout, msb first on the wire
	localparam int SEL_TYPE_HI = 7;
	localparam int SEL_TYPE_LO = 4;
	localparam int SEL_CE_BIT  = 3;
	localparam int SEL_A17_BIT = 2;
	localparam int SEL_A16_BIT = 1;
	localparam int SEL_RW_BIT  = 0;
	localparam logic SEL_RW_READ = 1'b1;

	// device type identifiers; both values are arbitrary
	localparam logic [3:0] ARRAY_TYPE_ID = 4'h5;
	localparam logic [3:0] IDPAGE_TYPE_ID = 4'h6;

	// bit counting within a byte
	localparam logic [3:0] BYTE_BITS    = 4'h8;
	localparam logic [3:0] LAST_OUT_BIT = 4'h7;

	// reset and erased values
	localparam logic [7:0]        ERASED_BYTE   = 8'hFF;
	localparam logic [ADDR_W-1:0] ADDR_RST      = 18'h00000;
	localparam logic [ADDR_W-1:0] ADDR_ONE      = 18'h00001;
	localparam logic [9:0]        ID_HI_ZERO    = 10'h000;

	// protocol states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_DEVSEL = 3'b001,
		ST_ADDRH  = 3'b010,
		ST_ADDRL  = 3'b011,
		ST_WDATA  = 3'b100,
		ST_ACK    = 3'b101,
		ST_RDATA  = 3'b110,
		ST_RACK   = 3'b111
	} eesrp_state_t;

endpackage

/* verilog/eesrp_mem.sv */
/*
 eesrp_mem: byte memory with one write port and a registered read port.
 Assumes a single clock with clock enable; contents start erased.
*/
`timescale 1ns/1ps
`default_nettype none

module eesrp_mem
#(
	parameter int AW = 8
)
(
	input  wire logic          core_clk,
	input  wire logic          clkEn,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [7:0]    wrData,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [7:0]    rdData
);
	import eesrp_pkg::*;

	logic [7:0] mem [0:(1<<AW)-1];
	logic [7:0] rdData_reg;

	// delivered state: every byte erased
	initial
	begin
		for (int i = 0; i < (1 << AW); i++)
			mem[i] = ERASED_BYTE;
	end

	// read data always from a register, one cycle after the address
	always_ff @(posedge core_clk)
	begin
		if (clkEn)
		begin
			if (wrEn)
				mem[wrAddr] <= wrData;
			rdData_reg <= mem[rdAddr];
		end
	end

	assign rdData = rdData_reg;

endmodule
`default_nettype wire

/* verilog/eesrp_read_path.sv */
/*
 eesrp_read_path: two-wire target logic for reads of the eeprom array
 and identification page, with the shared address counter.
 Assumes scl, sda and the chip enable pin are asynchronous and are
 synchronised here; write engine signals come from core_clk logic.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - reads behave the same whatever the write protect pin does.
// - a completed read advances the address counter by one.
// - after each output byte release data and sample the ack in bit nine.
// - no ack in bit nine stops the output and returns to standby.
// - device acks the read select and sends the addressed byte.
// - current-address read acks, sends byte at counter, then increments it.
// - one counter serves array and id page; id access loads page offset.
// - each acked byte with more clocks yields the next consecutive byte.
// - counter increments per byte and wraps to zero after the top address.
// - id page read uses random read protocol with its own type id.
// - id page ignores upper address bits, low byte is the offset.
// - lock probe data byte acked when unlocked, not acked when locked.
// - a start mid-command resets the logic and drops the command.
// - a stop returns the device to standby.
// - array and id page read as all ones when delivered.
// - the select byte's last bit gives direction, one for read.
// - respond only when the chip enable bit matches the pin.
// - array address has 18 bits, two from select, sixteen from bytes.
// - during an internal write cycle all requests are ignored.
module eesrp_read_path
(
	input  wire logic                          core_clk,
	input  wire logic                          rst_b,
	input  wire logic                          clkEn,
	input  wire logic                          sclIn,
	input  wire logic                          sdaIn,
	output logic                               sdaOut,
	output logic                               sdaOe,
	input  wire logic                          write_protect_input,
	input  wire logic                          chip_enable_select_input,
	input  wire logic                          writeBusy,
	input  wire logic                          idLocked,
	input  wire logic                          memWrEn,
	input  wire logic                          memWrId,
	input  wire logic [eesrp_pkg::ADDR_W-1:0]  memWrAddr,
	input  wire logic [7:0]                    memWrData,
	output logic [eesrp_pkg::ADDR_W-1:0]       addrCounter,
	output logic                               deviceActive
);
	import eesrp_pkg::*;

	// pin synchronisers and edge history
	logic sclMeta_reg;
	logic sclSync_reg;
	logic sclPrev_reg;
	logic sdaMeta_reg;
	logic sdaSync_reg;
	logic sdaPrev_reg;
	logic ceMeta_reg;
	logic ceSync_reg;

	// protocol state
	eesrp_state_t      state_reg;
	eesrp_state_t      state_next;
	eesrp_state_t      retState_reg;
	eesrp_state_t      retState_next;
	logic [3:0]        bitCnt_reg;
	logic [3:0]        bitCnt_next;
	logic [7:0]        shift_reg;
	logic [7:0]        shift_next;
	logic [ADDR_W-1:0] addrCnt_reg;
	logic [ADDR_W-1:0] addrCnt_next;
	logic [7:0]        addrHi_reg;
	logic [7:0]        addrHi_next;
	logic [1:0]        selHi_reg;
	logic [1:0]        selHi_next;
	logic              isId_reg;
	logic              isId_next;
	logic              pullLow_reg;
	logic              pullLow_next;
	logic              masterAck_reg;
	logic              masterAck_next;

	// bus events and memory data
	logic              sclRise;
	logic              sclFall;
	logic              startCond;
	logic              stopCond;
	logic              selMatch;
	logic [7:0]        arrRdData;
	logic [7:0]        idRdData;
	logic [7:0]        memData;

	// two flops on the scl, sda and chip enable pins before any logic looks at them
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			sclMeta_reg <= 1'b1;
			sclSync_reg <= 1'b1;
			sclPrev_reg <= 1'b1;
			sdaMeta_reg <= 1'b1;
			sdaSync_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
			ceMeta_reg  <= 1'b0;
			ceSync_reg  <= 1'b0;
		end
		else if (clkEn)
		begin
			sclMeta_reg <= sclIn;
			sclSync_reg <= sclMeta_reg;
			sclPrev_reg <= sclSync_reg;
			sdaMeta_reg <= sdaIn;
			sdaSync_reg <= sdaMeta_reg;
			sdaPrev_reg <= sdaSync_reg;
			ceMeta_reg  <= chip_enable_select_input;
			ceSync_reg  <= ceMeta_reg;
		end
	end

	// edges of scl, and sda moving while scl stays high
	assign sclRise   = sclSync_reg & ~sclPrev_reg;
	assign sclFall   = ~sclSync_reg & sclPrev_reg;
	assign startCond = sclSync_reg & sclPrev_reg & sdaPrev_reg & ~sdaSync_reg;
	assign stopCond  = sclSync_reg & sclPrev_reg & ~sdaPrev_reg & sdaSync_reg;

	// select matches a known type and the chip enable strap
	assign selMatch = ((shift_reg[SEL_TYPE_HI:SEL_TYPE_LO] == ARRAY_TYPE_ID) ||
		(shift_reg[SEL_TYPE_HI:SEL_TYPE_LO] == IDPAGE_TYPE_ID)) &&
		(shift_reg[SEL_CE_BIT] == ceSync_reg);

	// id page sees only the low byte of the shared counter
	assign memData = isId_reg ? idRdData : arrRdData;

	// array storage; the write engine owns the write port
	eesrp_mem #(.AW(ADDR_W)) arrayMem
	(
		.core_clk (core_clk),
		.clkEn    (clkEn),
		.wrEn     (memWrEn & ~memWrId),
		.wrAddr   (memWrAddr),
		.wrData   (memWrData),
		.rdAddr   (addrCnt_reg),
		.rdData   (arrRdData)
	);

	// identification page storage
	eesrp_mem #(.AW(ID_AW)) idPageMem
	(
		.core_clk (core_clk),
		.clkEn    (clkEn),
		.wrEn     (memWrEn & memWrId),
		.wrAddr   (memWrAddr[ID_AW-1:0]),
		.wrData   (memWrData),
		.rdAddr   (addrCnt_reg[ID_AW-1:0]),
		.rdData   (idRdData)
	);

	// protocol next state; write protect is never consulted on reads
	always_comb
	begin
		state_next     = state_reg;
		retState_next  = retState_reg;
		bitCnt_next    = bitCnt_reg;
		shift_next     = shift_reg;
		addrCnt_next   = addrCnt_reg;
		addrHi_next    = addrHi_reg;
		selHi_next     = selHi_reg;
		isId_next      = isId_reg;
		pullLow_next   = pullLow_reg;
		masterAck_next = masterAck_reg;
		if (startCond)
		begin
			// a write cycle in progress hides the device entirely
			state_next   = writeBusy ? ST_IDLE : ST_DEVSEL;
			bitCnt_next  = 4'h0;
			pullLow_next = 1'b0;
		end
		else if (stopCond)
		begin
			state_next   = ST_IDLE;
			pullLow_next = 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					pullLow_next = 1'b0;
				end
				ST_DEVSEL, ST_ADDRH, ST_ADDRL, ST_WDATA:
				begin
					if (sclRise && (bitCnt_reg < BYTE_BITS))
					begin
						shift_next  = {shift_reg[6:0], sdaSync_reg};
						bitCnt_next = bitCnt_reg + 4'h1;
					end
					else if (sclFall && (bitCnt_reg == BYTE_BITS))
					begin
						state_next   = ST_ACK;
						pullLow_next = 1'b1;
						if (state_reg == ST_DEVSEL)
						begin
							if (selMatch)
							begin
								isId_next = (shift_reg[SEL_TYPE_HI:SEL_TYPE_LO] ==
									IDPAGE_TYPE_ID);
								if (shift_reg[SEL_RW_BIT] == SEL_RW_READ)
								begin
									retState_next = ST_RDATA;
								end
								else
								begin
									retState_next = ST_ADDRH;
									selHi_next = {shift_reg[SEL_A17_BIT],
										shift_reg[SEL_A16_BIT]};
								end
							end
							else
							begin
								// not ours: stay silent until the next start
								state_next   = ST_IDLE;
								pullLow_next = 1'b0;
							end
						end
						else if (state_reg == ST_ADDRH)
						begin
							addrHi_next   = shift_reg;
							retState_next = ST_ADDRL;
						end
						else if (state_reg == ST_ADDRL)
						begin
							// dummy write loads the shared counter
							if (isId_reg)
								addrCnt_next = {ID_HI_ZERO, shift_reg};
							else
								addrCnt_next = {selHi_reg, addrHi_reg, shift_reg};
							retState_next = ST_WDATA;
						end
						else
						begin
							// lock probe answer; the data is never kept here
							retState_next = ST_WDATA;
							pullLow_next  = isId_reg ? ~idLocked : ~write_protect_input;
						end
					end
				end
				ST_ACK:
				begin
					// hold the ack through bit nine, let go when scl falls
					if (sclFall)
					begin
						bitCnt_next = 4'h0;
						state_next  = retState_reg;
						if (retState_reg == ST_RDATA)
						begin
							shift_next   = memData;
							pullLow_next = ~memData[7];
						end
						else
						begin
							pullLow_next = 1'b0;
						end
					end
				end
				ST_RDATA:
				begin
					// only scl low moves the line, so no false start or stop
					if (sclFall)
					begin
						if (bitCnt_reg == LAST_OUT_BIT)
						begin
							pullLow_next = 1'b0;
							state_next   = ST_RACK;
							// id page keeps its counter inside the page, upper bits at zero
							addrCnt_next = isId_reg ?
								{ID_HI_ZERO, addrCnt_reg[ID_AW-1:0] + 8'h01} :
								addrCnt_reg + ADDR_ONE;
						end
						else
						begin
							shift_next   = {shift_reg[6:0], 1'b0};
							pullLow_next = ~shift_reg[6];
							bitCnt_next  = bitCnt_reg + 4'h1;
						end
					end
				end
				ST_RACK:
				begin
					if (sclRise)
					begin
						masterAck_next = ~sdaSync_reg;
					end
					else if (sclFall)
					begin
						bitCnt_next = 4'h0;
						if (masterAck_reg)
						begin
							// the counter moved one bus bit ago, so data is ready
							state_next   = ST_RDATA;
							shift_next   = memData;
							pullLow_next = ~memData[7];
						end
						else
						begin
							state_next   = ST_IDLE;
							pullLow_next = 1'b0;
						end
					end
				end
				default:
				begin
					state_next   = ST_IDLE;
					pullLow_next = 1'b0;
				end
			endcase
		end
	end

	// protocol registers, frozen while the clock enable is low
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			state_reg     <= ST_IDLE;
			retState_reg  <= ST_IDLE;
			bitCnt_reg    <= 4'h0;
			shift_reg     <= 8'h00;
			addrCnt_reg   <= ADDR_RST;
			addrHi_reg    <= 8'h00;
			selHi_reg     <= 2'h0;
			isId_reg      <= 1'b0;
			pullLow_reg   <= 1'b0;
			masterAck_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			state_reg     <= state_next;
			retState_reg  <= retState_next;
			bitCnt_reg    <= bitCnt_next;
			shift_reg     <= shift_next;
			addrCnt_reg   <= addrCnt_next;
			addrHi_reg    <= addrHi_next;
			selHi_reg     <= selHi_next;
			isId_reg      <= isId_next;
			pullLow_reg   <= pullLow_next;
			masterAck_reg <= masterAck_next;
		end
	end

	// open drain: only ever pull low
	assign sdaOut       = 1'b0;
	assign sdaOe        = pullLow_reg;
	assign addrCounter  = addrCnt_reg;
	assign deviceActive = (state_reg != ST_IDLE);

endmodule
`default_nettype wire

/* tb/eesrp_sva.sv */
/*
 eesrp_sva: port checks for the eeprom read path.
 Assumes one clock domain and a data wire resolved by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module eesrp_sva
(
	input wire logic                         core_clk,
	input wire logic                         rst_b,
	input wire logic                         clkEn,
	input wire logic                         sclIn,
	input wire logic                         sdaIn,
	input wire logic                         sdaOut,
	input wire logic                         sdaOe,
	input wire logic                         writeBusy,
	input wire logic                         deviceActive,
	input wire logic [eesrp_pkg::ADDR_W-1:0] addrCounter
);
	import eesrp_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// open drain: the pin is never driven high
	drive_low_a: assert property (sdaOut == 1'b0)
		else $error("data driven high");
	// pull-down may only begin while the clock pin is low
	oe_on_low_a: assert property ($rose(sdaOe) |-> !$past(sclIn, 2))
		else $error("pull-down began with clock high");
	// a pulled bit stands for a whole bus bit
	ack_len_a: assert property ($rose(sdaOe) |-> sdaOe[*8])
		else $error("pulled bit too short");
	// counter moves only inside a transaction
	cnt_idle_a: assert property (!deviceActive && $past(deviceActive) == 1'b0
		|-> $stable(addrCounter)) else $error("counter moved in standby");
	// standby never pulls the line
	idle_quiet_a: assert property (!deviceActive && $past(deviceActive) == 1'b0
		|-> !sdaOe) else $error("pull-down in standby");
	// a running write cycle keeps the target in standby
	busy_ign_a: assert property (writeBusy && !deviceActive |=> !deviceActive)
		else $error("request taken while busy");
	// a start wakes the target within the sync delay
	start_wake_a: assert property (clkEn && !writeBusy && sclIn && $past(sclIn) && $fell(sdaIn)
		|-> ##[1:5] deviceActive) else $error("start not taken");
	// a stop returns to standby within the sync delay
	stop_idle_a: assert property (clkEn && sclIn && $past(sclIn) && $rose(sdaIn)
		|-> ##[1:5] !deviceActive) else $error("stop not taken");
	cover property ($rose(sdaOe));
	cover property (deviceActive ##1 !deviceActive);
	cover property ($changed(addrCounter) && addrCounter == ADDR_RST);
endmodule
`default_nettype wire

/* tb/eesrp_bus_master.sv */
/*
 eesrp_bus_master: behavioural two-wire controller.
 Assumes a pull-up on the data wire; clock idles high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module eesrp_bus_master
(
	input  wire logic core_clk,
	input  wire logic sdaLine,
	output var logic  scl,
	output var logic  sdaRel
);
	initial
	begin
		scl = 1'b1;
		sdaRel = 1'b1;
	end
	// wait whole core cycles
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one bit: 4 cycles low then 4 high, data moved only while low
	task automatic bitx(input logic b, output logic r);
		w(1);
		sdaRel <= b;
		w(3);
		scl <= 1'b1;
		w(2);
		r = sdaLine;
		w(2);
		scl <= 1'b0;
	endtask
	// start, also usable as repeated start from a low clock
	task automatic start();
		w(1);
		sdaRel <= 1'b1;
		w(3);
		scl <= 1'b1;
		w(3);
		sdaRel <= 1'b0;
		w(3);
		scl <= 1'b0;
	endtask
	// stop leaves the bus idle, both lines high
	task automatic stop();
		w(1);
		sdaRel <= 1'b0;
		w(3);
		scl <= 1'b1;
		w(3);
		sdaRel <= 1'b1;
		w(4);
	endtask
	// byte out msb first; ack is what bit nine carried
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	// byte in; no ack ends the stream
	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(!ack, r);
	endtask
endmodule
`default_nettype wire

/* tb/test_serial_eeprom_read_path.sv */
/*
 test_serial_eeprom_read_path: self-checking bench for the read path.
 Assumes the master model owns the clock pin; data has a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
bind eesrp_read_path eesrp_sva chk_i (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
	.sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeBusy(writeBusy),
	.deviceActive(deviceActive), .addrCounter(addrCounter));
module test_serial_eeprom_read_path;
	import eesrp_pkg::*;
	logic              core_clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              ceStrap = 1'b0;
	logic              wProt = 1'b0;
	logic              writeBusy = 1'b0;
	logic              idLocked = 1'b0;
	logic              memWrEn = 1'b0;
	logic              memWrId = 1'b0;
	logic [ADDR_W-1:0] memWrAddr = ADDR_RST;
	logic [7:0]        memWrData = 8'h00;
	logic              sclIn, sdaRel, sdaOut, sdaOe, deviceActive, k;
	logic [ADDR_W-1:0] addrCounter, a;
	wire logic         sdaIn = sdaRel & (sdaOe ? sdaOut : 1'b1);
	logic [7:0]        arr [logic [ADDR_W-1:0]];
	logic [7:0]        idp [logic [ADDR_W-1:0]];
	int                n_fail = 0;
	int                tests_run = 0;
	int                seed = 32'hEF2B;
	always #10 core_clk = ~core_clk;
	eesrp_bus_master m (.core_clk(core_clk), .sdaLine(sdaIn), .scl(sclIn), .sdaRel(sdaRel));
	eesrp_read_path dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(1'b1), .sclIn(sclIn),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .write_protect_input(wProt),
		.chip_enable_select_input(ceStrap), .writeBusy(writeBusy), .idLocked(idLocked),
		.memWrEn(memWrEn), .memWrId(memWrId), .memWrAddr(memWrAddr),
		.memWrData(memWrData), .addrCounter(addrCounter), .deviceActive(deviceActive));
	// expected byte: last stored value, erased otherwise
	function automatic logic [7:0] exp8(input logic id, input logic [ADDR_W-1:0] x);
		if (id)
			return idp.exists(x) ? idp[x] : ERASED_BYTE;
		return arr.exists(x) ? arr[x] : ERASED_BYTE;
	endfunction
	// next counter; the id page wraps inside its low byte
	function automatic logic [ADDR_W-1:0] nxt(input logic id, input logic [ADDR_W-1:0] x);
		return id ? {ID_HI_ZERO, x[7:0] + 8'h01} : x + ADDR_ONE;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// fill storage through the write engine port
	task automatic store(input logic id, input logic [ADDR_W-1:0] x, input logic [7:0] d);
		memWrEn <= 1'b1;
		memWrId <= id;
		memWrAddr <= x;
		memWrData <= d;
		@(posedge core_clk);
		memWrEn <= 1'b0;
		@(posedge core_clk);
		if (id)
			idp[x] = d;
		else
			arr[x] = d;
	endtask
	// read select, then n bytes from x, last one unacked
	task automatic curr(input logic [3:0] t, input int n, input logic [ADDR_W-1:0] x);
		logic [7:0] d;
		m.start();
		m.put({t, ceStrap, 2'b00, SEL_RW_READ}, k);
		chk(k, 1'h1);
		for (int i = 0; i < n; i++)
		begin
			m.get(i < n - 1, d);
			chk(d, exp8(t == IDPAGE_TYPE_ID, x));
			x = nxt(t == IDPAGE_TYPE_ID, x);
		end
		m.w(5);
		chk(deviceActive, 1'h0);
		m.stop();
		chk(addrCounter, x);
	endtask
	// dummy write loads the address, repeated start reads
	task automatic rread(input logic [3:0] t, input logic [ADDR_W-1:0] x, input int n);
		m.start();
		m.put({t, ceStrap, x[17:16], 1'b0}, k);
		chk(k, 1'h1);
		m.put(x[15:8], k);
		m.put(x[7:0], k);
		chk(k, 1'h1);
		curr(t, n, t == IDPAGE_TYPE_ID ? {ID_HI_ZERO, x[7:0]} : x);
	endtask
	// select that must get no acknowledge
	task automatic nope(input logic [7:0] s);
		m.start();
		m.put(s, k);
		chk(k, 1'h0);
		m.stop();
		chk(deviceActive, 1'h0);
	endtask
	initial
	begin
		ceStrap <= 1'($random(seed));
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({addrCounter, sdaOe, deviceActive}, 32'h0);
		curr(ARRAY_TYPE_ID, 1, ADDR_RST);
		for (int i = 0; i < 4; i++)
			store(1'b0, 18'h3FFFE + 18'(i), 8'($random(seed)));
		store(1'b1, 18'h00010, 8'($random(seed)));
		store(1'b1, 18'h00011, 8'($random(seed)));
		rread(ARRAY_TYPE_ID, 18'h3FFFE, 4);
		for (int i = 0; i < 6; i++)
		begin
			wProt <= 1'($random(seed));
			a = 18'($random(seed));
			store(1'b0, a, 8'($random(seed)));
			rread(ARRAY_TYPE_ID, a, 1 + i % 3);
		end
		rread(IDPAGE_TYPE_ID, {10'($random(seed)), 8'h10}, 2);
		curr(ARRAY_TYPE_ID, 1, 18'h00012);
		// lock probe on the id page, then the same truncated write to the array;
		// the pin that must not matter is set opposite, so a mixed-up pin shows
		for (int i = 0; i < 4; i++)
		begin
			idLocked <= i[0] ^ i[1];
			wProt <= ~(i[0] ^ i[1]);
			m.start();
			m.put({i[1] ? ARRAY_TYPE_ID : IDPAGE_TYPE_ID, ceStrap, 3'b000}, k);
			m.put(8'h00, k);
			m.put(8'h20, k);
			m.put(8'hA5, k);
			chk(k, !i[0]);
			m.start();
			m.stop();
			chk(deviceActive, 1'h0);
		end
		nope({ARRAY_TYPE_ID, !ceStrap, 2'b00, SEL_RW_READ});
		nope({4'hC, ceStrap, 2'b00, SEL_RW_READ});
		writeBusy <= 1'b1;
		nope({ARRAY_TYPE_ID, ceStrap, 2'b00, SEL_RW_READ});
		writeBusy <= 1'b0;
		stop_test();
	end
	// hang guard, well past the expected run length
	initial
	begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		stop_test();
	end
endmodule
`default_nettype wire
